// *** wp_consts.svh ***
`ifndef WP_CONSTS_SVH
`define WP_CONSTS_SVH

// core clock period and key auto-repeat period
`define CLK_NS 20
`define REPEAT_NS 200000

// register byte offsets
`define A_CTRL 6'h00
`define A_VAL 6'h04
`define A_CARE 6'h08
`define A_STAT 6'h0c
`define A_MASK 6'h10
`define A_EDIT 6'h14
`define A_VIEW 6'h18
`define A_MENU 6'h1c
`define A_HOLD 6'h20

// control fields
`define C_CLOCKLESS 0
`define C_FALLING 1
`define C_SRC_MAIN 2
`define C_SRC_DLY 3
`define C_ACQ 4
`define C_HEX 5

// status and mask fields
`define S_MATCH 0
`define S_FAULT 1
`define S_TRIG 2

// reset values
`define CTRL_RST 6'h00
`define VAL_RST 17'h00000
`define CARE_RST 17'h1ffff
`define MASK_RST 3'h0
`define HOLD_RST 16'h0000

// cursor position of the qualifier, the highest one
`define CUR_MAX 5'h10

`endif

// *** wp_pkg.sv ***
`default_nettype none

package wp_pkg;

   typedef struct packed {
      logic present;
      logic clk;
      logic qual;
      logic [15:0] data;
   } probe_s;

   typedef enum logic [2:0] {
      KEY_NONE,
      KEY_ONE,
      KEY_ZERO,
      KEY_X,
      KEY_LEFT,
      KEY_RIGHT
   } key_e;

   typedef struct packed {
      probe_s s1;
      probe_s s2;
      probe_s s3;
      probe_s stb;
      logic [5:0] ctrl;
      logic [16:0] val;
      logic [16:0] care;
      logic [2:0] status;
      logic [2:0] mask;
      logic [15:0] hold_len;
      logic [15:0] hold_cnt;
      logic [4:0] cur;
      logic dir;
      key_e key;
      logic [15:0] rep;
      logic last_m;
      logic waitreq;
      logic [31:0] rdata;
      logic match_o;
      logic main_o;
      logic dly_o;
      logic bell_o;
      logic irq_o;
   } core_s;

endpackage : wp_pkg

`default_nettype wire

// *** parallel_word_match_trigger.sv ***
`include "wp_consts.svh"
`default_nettype none

module parallel_word_match_trigger #(
   parameter logic [15:0] REPEAT_CYC = 16'(`REPEAT_NS / `CLK_NS)
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output var logic [31:0] avs_readdata,
   output var logic avs_waitrequest,
   input wire wp_pkg::probe_s probe_input_port,
   output var logic match_pulse_output,
   output var logic main_trig,
   output var logic delayed_trig,
   output var logic warn_bell,
   output var logic irq
);
   import wp_pkg::*;

   core_s st;
   core_s nx;
   logic acc;
   logic m_now;
   logic edge_hit;
   logic do_act;
   logic flt;
   logic [2:0] clr;
   logic [16:0] in17;
   logic [31:0] tmp;
   key_e ak;

   function automatic logic match17(input logic [16:0] v, input logic [16:0] c, input logic [16:0] x);
      return &(~c | ~(v ^ x));
   endfunction : match17

   function automatic logic [4:0] step(input logic [4:0] p, input logic d);
      if (d) begin
         return (p == `CUR_MAX) ? 5'h00 : 5'(p + 5'h01);
      end
      return (p == 5'h00) ? `CUR_MAX : 5'(p - 5'h01);
   endfunction : step

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] w, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = w[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   // five bits per digit: bit 4 flags a digit with a don't-care bit
   function automatic logic [29:0] display_base_select_view(input logic [15:0] v, input logic [15:0] c, input logic hex);
      logic [29:0] r;
      int w;
      int k;
      r = '0;
      w = hex ? 4 : 3;
      for (int i = 0; i < 6; i++) begin
         for (int j = 0; j < 4; j++) begin
            k = i * w + j;
            if (j < w && k < 16) begin
               r[i*5+j] = v[k];
               if (!c[k]) begin
                  r[i*5+4] = 1'b1;
               end
            end
         end
      end
      return r;
   endfunction : display_base_select_view

   always_comb begin
      nx = st;
      flt = 1'b0;
      clr = 3'h0;
      tmp = 32'h0;
      do_act = 1'b0;
      ak = st.key;
      acc = (avs_read | avs_write) & ~st.waitreq;
      // one wait cycle, then a single answer cycle with waitrequest low
      nx.waitreq = ~((avs_read | avs_write) & st.waitreq);

      // three-stage sampling; a bit counts once stages two and three agree
      nx.s1 = probe_input_port;
      nx.s2 = st.s1;
      nx.s3 = st.s2;
      nx.stb = probe_s'((~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.stb));

      in17 = {nx.stb.qual, nx.stb.data};
      m_now = match17(st.val, st.care, in17);
      edge_hit = (nx.stb.clk != st.stb.clk) & (nx.stb.clk ^ st.ctrl[`C_FALLING]);
      nx.last_m = m_now;
      if (st.ctrl[`C_CLOCKLESS]) begin
         nx.match_o = m_now & ~st.last_m;
      end else begin
         nx.match_o = edge_hit & m_now;
      end

      nx.main_o = 1'b0;
      nx.dly_o = 1'b0;
      if (st.hold_cnt != 16'h0000) begin
         nx.hold_cnt = 16'(st.hold_cnt - 16'h0001);
      end
      if (nx.match_o && st.hold_cnt == 16'h0000 && (st.ctrl[`C_SRC_MAIN] || st.ctrl[`C_SRC_DLY])) begin
         nx.main_o = st.ctrl[`C_SRC_MAIN];
         nx.dly_o = st.ctrl[`C_SRC_DLY];
         nx.hold_cnt = st.hold_len;
      end

      if (st.stb.present && !nx.stb.present && st.ctrl[`C_ACQ] && (st.ctrl[`C_SRC_MAIN] || st.ctrl[`C_SRC_DLY])) begin
         flt = 1'b1;
      end

      if (st.key != KEY_NONE) begin
         if (st.rep <= 16'h0001) begin
            do_act = 1'b1;
            nx.rep = REPEAT_CYC;
         end else begin
            nx.rep = 16'(st.rep - 16'h0001);
         end
      end

      if (acc && avs_write) begin
         unique case (avs_address)
            `A_CTRL: begin
               tmp = merge({26'h0, st.ctrl}, avs_writedata, avs_byteenable);
               if (!st.stb.present && (|(tmp[3:2] & ~st.ctrl[3:2]))) begin
                  flt = 1'b1;
                  tmp[3:2] = st.ctrl[3:2];
               end
               nx.ctrl = tmp[5:0];
            end
            `A_VAL: begin
               tmp = merge({15'h0, st.val}, avs_writedata, avs_byteenable);
               if (!st.stb.present) begin
                  flt = 1'b1;
               end else begin
                  nx.val = tmp[16:0];
               end
            end
            `A_CARE: begin
               tmp = merge({15'h0, st.care}, avs_writedata, avs_byteenable);
               if (!st.stb.present) begin
                  flt = 1'b1;
               end else begin
                  nx.care = tmp[16:0];
               end
            end
            `A_STAT: begin
               tmp = merge(32'h0, avs_writedata, avs_byteenable);
               clr = tmp[2:0];
            end
            `A_MASK: begin
               tmp = merge({29'h0, st.mask}, avs_writedata, avs_byteenable);
               nx.mask = tmp[2:0];
            end
            `A_EDIT: begin
               if (avs_byteenable[0]) begin
                  ak = (avs_writedata[2:0] > 3'(KEY_RIGHT)) ? KEY_NONE : key_e'(avs_writedata[2:0]);
                  nx.key = ak;
                  nx.rep = REPEAT_CYC;
                  do_act = (ak != KEY_NONE);
               end
            end
            `A_HOLD: begin
               tmp = merge({16'h0, st.hold_len}, avs_writedata, avs_byteenable);
               nx.hold_len = tmp[15:0];
            end
            default: begin
            end
         endcase
      end

      if (do_act) begin
         unique case (ak)
            KEY_LEFT: begin
               nx.dir = 1'b1;
               nx.cur = step(st.cur, 1'b1);
            end
            KEY_RIGHT: begin
               nx.dir = 1'b0;
               nx.cur = step(st.cur, 1'b0);
            end
            KEY_ONE, KEY_ZERO, KEY_X: begin
               if (!st.stb.present) begin
                  flt = 1'b1;
               end else begin
                  nx.val[st.cur] = (ak == KEY_ONE);
                  nx.care[st.cur] = (ak != KEY_X);
                  nx.cur = step(st.cur, st.dir);
               end
            end
            KEY_NONE: begin
            end
         endcase
      end

      // sticky status: a new event wins over a same-cycle clear
      nx.status = (st.status & ~clr) | {nx.main_o | nx.dly_o, flt, nx.match_o};
      nx.irq_o = |(nx.status & nx.mask);
      nx.bell_o = flt;

      if ((avs_read || avs_write) && st.waitreq) begin
         unique case (avs_address)
            `A_CTRL: nx.rdata = {26'h0, st.ctrl};
            `A_VAL: nx.rdata = {15'h0, st.val};
            `A_CARE: nx.rdata = {15'h0, st.care};
            `A_STAT: nx.rdata = {29'h0, st.status};
            `A_MASK: nx.rdata = {29'h0, st.mask};
            `A_EDIT: nx.rdata = {13'h0, 3'(st.key), 7'h0, st.dir, 3'h0, st.cur};
            `A_VIEW: nx.rdata = {st.ctrl[`C_HEX], 1'b0, display_base_select_view(st.val[15:0], st.care[15:0], st.ctrl[`C_HEX])};
            `A_MENU: nx.rdata = {29'h0, st.stb.present, st.ctrl[`C_SRC_DLY], st.ctrl[`C_SRC_MAIN]};
            `A_HOLD: nx.rdata = {16'h0, st.hold_len};
            default: nx.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.waitreq <= 1'b1;
         st.ctrl <= `CTRL_RST;
         st.val <= `VAL_RST;
         st.care <= `CARE_RST;
         st.mask <= `MASK_RST;
         st.hold_len <= `HOLD_RST;
      end else begin
         st <= nx;
      end
   end

   assign match_pulse_output = st.match_o;
   assign main_trig = st.main_o;
   assign delayed_trig = st.dly_o;
   assign warn_bell = st.bell_o;
   assign irq = st.irq_o;
   assign avs_readdata = st.rdata;
   assign avs_waitrequest = st.waitreq;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   clocked_edge_a: assert property (
      match_pulse_output && !$past(st.ctrl[`C_CLOCKLESS])
      |-> st.stb.clk != $past(st.stb.clk) && st.stb.clk == !$past(st.ctrl[`C_FALLING]))
      else $error("clocked match without the selected edge");

   match_value_a: assert property (
      match_pulse_output |-> match17($past(st.val), $past(st.care), {st.stb.qual, st.stb.data}))
      else $error("match pulse on a word that misses the pattern");

   clockless_pulse_a: assert property (
      $past(st.ctrl[`C_CLOCKLESS]) |-> match_pulse_output == (st.last_m && !$past(st.last_m)))
      else $error("clockless match pulse wrong");

   holdoff_gate_a: assert property (
      (main_trig || delayed_trig) |-> match_pulse_output && $past(st.hold_cnt) == 16'h0000)
      else $error("trigger accepted during holdoff");

   route_split_a: assert property (
      (main_trig || delayed_trig) |-> main_trig == $past(st.ctrl[`C_SRC_MAIN])
      && delayed_trig == $past(st.ctrl[`C_SRC_DLY]))
      else $error("trigger routed to the wrong output");

   source_keep_a: assert property (
      acc && avs_write && avs_address == `A_CTRL && !st.stb.present && avs_byteenable[0]
      && (|(avs_writedata[3:2] & ~st.ctrl[3:2]))
      |=> st.ctrl[3:2] == $past(st.ctrl[3:2]) && st.status[`S_FAULT] && warn_bell)
      else $error("source taken without probe");

   removal_fault_a: assert property (
      $past(st.stb.present) && !st.stb.present && $past(st.ctrl[`C_ACQ])
      && $past(st.ctrl[3:2]) != 2'b00 |-> st.status[`S_FAULT] && warn_bell)
      else $error("probe removal not flagged");

   frozen_edit_a: assert property (
      acc && avs_write && avs_address == `A_VAL && !st.stb.present
      |=> st.val == $past(st.val) && warn_bell ##1 st.status[`S_FAULT])
      else $error("pattern changed without probe");

   cursor_wrap_a: assert property (
      do_act && ak == KEY_ONE && st.stb.present && st.cur == `CUR_MAX && st.dir
      |=> st.cur == 5'h00 && st.val[16] && st.care[16])
      else $error("cursor did not wrap after setting the qualifier");

   menu_letters_a: assert property (
      avs_read && !avs_waitrequest && avs_address == `A_MENU
      |-> avs_readdata[1:0] == $past(st.ctrl[3:2]))
      else $error("menu letters do not show the routing");

   clocked_trig_c: cover property (!st.ctrl[`C_CLOCKLESS] && main_trig);
   clockless_match_c: cover property (st.ctrl[`C_CLOCKLESS] && match_pulse_output);
   holdoff_drop_c: cover property (match_pulse_output && !main_trig && !delayed_trig && st.ctrl[3:2] != 2'b00);
   removal_c: cover property ($fell(st.stb.present) && st.ctrl[`C_ACQ]);
   key_wrap_c: cover property (do_act && st.cur == `CUR_MAX && st.dir);

endmodule : parallel_word_match_trigger

`default_nettype wire

// *** word_probe_model.sv ***
`default_nettype none

module word_probe_model (
   input wire logic attach,
   input wire logic run,
   input wire logic [16:0] word,
   output var wp_pkg::probe_s pins
);
   timeunit 1ns;
   timeprecision 1ns;
   import wp_pkg::*;

   logic lclk;

   // link clock only runs inside a frame and rests low between frames
   initial begin
      lclk = 1'b0;
      #7;
      forever begin
         #80;
         lclk = run ? ~lclk : 1'b0;
      end
   end

   // a detached connector floats: show the inverse word, never a stale copy
   always_comb begin
      pins = attach ? {1'b1, lclk, word} : {1'b0, 1'b0, ~word};
   end
endmodule : word_probe_model

`default_nettype wire

// *** parallel_word_match_trigger_tb_top.sv ***
`include "wp_consts.svh"
`default_nettype none
`define chk(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin mismatches++; \
   $display("Error %s expected %0h seen %0h", nm, ex, got); end end

module parallel_word_match_trigger_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import wp_pkg::*;

   logic core_clk, rst_n, avs_read, avs_write, attach, run;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [3:0] avs_byteenable;
   logic [16:0] word;
   logic [4:0] c;
   logic avs_waitrequest, match_pulse_output, main_trig, delayed_trig, warn_bell, irq;
   probe_s pins;
   int mismatches, total_checks, n_m, n_main, n_dly, n_bell, n_rise, n_fall;

   parallel_word_match_trigger #(.REPEAT_CYC(16'd8)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .probe_input_port(pins), .match_pulse_output(match_pulse_output), .main_trig(main_trig),
      .delayed_trig(delayed_trig), .warn_bell(warn_bell), .irq(irq));
   word_probe_model far_end (.attach(attach), .run(run), .word(word), .pins(pins));

   always #10 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (match_pulse_output === 1'b1) n_m++;
      if (main_trig === 1'b1) n_main++;
      if (delayed_trig === 1'b1) n_dly++;
      if (warn_bell === 1'b1) n_bell++;
   end
   always @(posedge pins.clk) n_rise++;
   always @(negedge pins.clk) n_fall++;

   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle

   task automatic clr();
      n_m = 0;
      n_main = 0;
      n_dly = 0;
      n_bell = 0;
      n_rise = 0;
      n_fall = 0;
   endtask : clr

   // request held until waitrequest is sampled low, released only after that edge
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge core_clk);
         n++;
         if (n > 40) begin
            mismatches++;
            final_report();
         end
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
   endtask : bus

   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rdchk(input logic [5:0] a, input logic [31:0] ex, input string nm);
      bus(1'b0, a, 32'h0);
      `chk(nm, ex, q)
   endtask : rdchk

   task automatic t_absent();
      rdchk(`A_CARE, 32'h1ffff, "care");
      rdchk(6'h24, 32'h0, "unmapped");
      clr();
      wr(`A_CTRL, 32'h14);
      wr(`A_VAL, 32'h155);
      idle(3);
      `chk("bell", 2, n_bell)
      rdchk(`A_CTRL, 32'h10, "ctrl");
      rdchk(`A_VAL, 32'h0, "val");
      rdchk(`A_STAT, 32'h2, "stat");
      wr(`A_MASK, 32'h2);
      idle(2);
      `chk("irq", 1'b1, irq)
      wr(`A_STAT, 32'h2);
      idle(2);
      `chk("irq", 1'b0, irq)
   endtask : t_absent

   task automatic t_clockless();
      attach <= 1'b1;
      idle(8);
      wr(`A_VAL, 32'h1a5a5);
      wr(`A_CTRL, 32'h1d);
      clr();
      word <= 17'h1a5a5;
      run <= 1'b1;
      idle(40);
      run <= 1'b0;
      `chk("onset", 1, n_m)
      clr();
      word <= 17'h0a5a5;
      idle(10);
      `chk("qual", 0, n_m)
      wr(`A_CARE, 32'h0ffff);
      idle(4);
      `chk("dontcare", 1, n_m)
      wr(`A_CARE, 32'h1ffff);
      for (int s = 1; s < 4; s++) begin
         wr(`A_CTRL, 32'h11 | (s << 2));
         rdchk(`A_MENU, 32'h4 | s, "menu");
         word <= 17'h0;
         idle(6);
         clr();
         word <= 17'h1a5a5;
         idle(10);
         `chk("main", s & 1, n_main)
         `chk("dly", s >> 1, n_dly)
         `chk("pulse", 1, n_m)
      end
   endtask : t_clockless

   task automatic t_clocked();
      wr(`A_CTRL, 32'h14);
      word <= 17'h0;
      idle(6);
      clr();
      word <= 17'h1a5a5;
      idle(20);
      `chk("noedge", 0, n_m)
      for (int f = 0; f < 2; f++) begin
         wr(`A_CTRL, 32'h14 | (f << 1));
         clr();
         run <= 1'b1;
         idle(64);
         run <= 1'b0;
         idle(20);
         `chk("edges", f ? n_fall : n_rise, n_m)
      end
      wr(`A_HOLD, 32'd20);
      wr(`A_CTRL, 32'h14);
      clr();
      run <= 1'b1;
      idle(64);
      run <= 1'b0;
      idle(20);
      `chk("pulses", n_rise, n_m)
      `chk("accepted", (n_rise + 2) / 3, n_main)
   endtask : t_clocked

   task automatic t_removal();
      wr(`A_CTRL, 32'h15);
      clr();
      attach <= 1'b0;
      idle(8);
      `chk("removal", 1, n_bell)
      bus(1'b0, `A_STAT, 32'h0);
      `chk("fault", 1'b1, q[1])
      attach <= 1'b1;
      idle(8);
      wr(`A_CTRL, 32'h05);
      clr();
      attach <= 1'b0;
      idle(8);
      `chk("frozen", 0, n_bell)
      wr(`A_VAL, 32'h3);
      idle(3);
      `chk("edit", 1, n_bell)
      rdchk(`A_VAL, 32'h1a5a5, "val");
      attach <= 1'b1;
      idle(8);
   endtask : t_removal

   task automatic t_view();
      wr(`A_VAL, 32'h0b230);
      wr(`A_CARE, 32'h1fff0);
      // octal digits 1,3,1,0,6,0 with the low two flagged; hex b,2,3,0 with the low one flagged
      wr(`A_CTRL, 32'h0);
      rdchk(`A_VIEW, 32'h023082d0, "octal");
      wr(`A_CTRL, 32'h20);
      rdchk(`A_VIEW, 32'h80058870, "hex");
   endtask : t_view

   task automatic t_keys();
      // a key on a write without lane 0 must be ignored
      avs_byteenable <= 4'he;
      wr(`A_EDIT, 32'h4);
      avs_byteenable <= 4'hf;
      rdchk(`A_EDIT, 32'h0, "lane");
      // turn left first, so the held one walks up through the qualifier and wraps
      wr(`A_EDIT, 32'h4);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_EDIT, 32'h101, "left");
      wr(`A_EDIT, 32'h1);
      idle(200);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_VAL, 32'h1ffff, "all");
      rdchk(`A_CARE, 32'h1ffff, "allcare");
      bus(1'b0, `A_EDIT, 32'h0);
      c = 5'((q[4:0] + 1) % 17);
      wr(`A_EDIT, 32'h4);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_EDIT, {24'h1, 3'h0, c}, "step");
      wr(`A_EDIT, 32'h2);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_VAL, 32'h1ffff & ~(32'h1 << c), "bit");
      rdchk(`A_EDIT, {24'h1, 3'h0, 5'((c + 1) % 17)}, "advance");
      wr(`A_EDIT, 32'h5);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_EDIT, {27'h0, c}, "right");
      wr(`A_EDIT, 32'h3);
      wr(`A_EDIT, 32'h0);
      rdchk(`A_CARE, 32'h1ffff & ~(32'h1 << c), "xbit");
      rdchk(`A_EDIT, {27'h0, 5'((c + 16) % 17)}, "back");
   endtask : t_keys

   initial begin
      core_clk = 1'b0;
      rst_n = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 6'h00;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hf;
      attach = 1'b0;
      run = 1'b0;
      word = 17'h0;
      mismatches = 0;
      total_checks = 0;
      clr();
      idle(16);
      rst_n <= 1'b1;
      idle(1);
      t_absent();
      t_clockless();
      t_clocked();
      t_removal();
      t_view();
      t_keys();
      final_report();
   end
endmodule : parallel_word_match_trigger_tb_top

`default_nettype wire
